// ===== hdl/rts_pkg.sv
// Purpose: shared constants and types of the reset time-out sequencer
// Assumes: 40 MHz system clock, one oscillator tick pulse per period
// Notes:   register offsets are word indexes on an 8-bit port
package rts_pkg;

  // ==========================================================
  // timing
  localparam int CLK_MHZ      = 40;
  localparam int POWERUP_TIMER_TIME_US = 72000;
  localparam int POWERUP_TIMER_CYC     = POWERUP_TIMER_TIME_US * CLK_MHZ;
  localparam int OST_PERIODS  = 1024;
  localparam int POWERUP_TIMER_W       = 22;
  localparam int OST_W        = 11;
  localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_PERIODS - 1);

  // ==========================================================
  // oscillator modes
  localparam logic [1:0] OSC_LP = 2'h0;
  localparam logic [1:0] OSC_XT = 2'h1;
  localparam logic [1:0] OSC_HS = 2'h2;
  localparam logic [1:0] OSC_RC = 2'h3;

  // ==========================================================
  // program counter
  localparam logic [12:0] PC_RESET   = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC = 13'h0004;

  // ==========================================================
  // register map
  localparam logic [3:0] ADDR_PWR     = 4'h0;
  localparam logic [3:0] ADDR_STAT    = 4'h1;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'h3;
  localparam logic [3:0] ADDR_STATE   = 4'h4;

  localparam int PWR_BOR_BIT = 0;
  localparam int PWR_POR_BIT = 1;
  localparam logic [1:0] PWR_RST = 2'h0;

  // status bits 7:3 kept here; index 1 timeout, index 0 powerdown
  localparam int STAT_TO_BIT = 1;
  localparam int STAT_PD_BIT = 0;
  localparam logic [4:0] STAT_POR  = 5'h03;
  localparam logic [4:0] STAT_MSLP = 5'h02;
  localparam logic [4:0] STAT_WDTR = 5'h01;

  localparam int EV_REL  = 0;
  localparam int EV_BOR  = 1;
  localparam int EV_WDT  = 2;
  localparam int EV_WAKE = 3;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // ==========================================================
  // types
  typedef struct packed {
    logic osc_select_hi;
    logic osc_select_lo;
    logic powerup_timer_enable_n;
    logic brownout_detect_enable;
    logic global_irq_enable;
  } rts_cfg_type;

  typedef struct packed {
    logic por;
    logic brownout;
    logic wdt;
    logic irq_wake;
    logic sleep;
  } rts_evt_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } rts_bus_type;

  typedef enum logic [2:0] {
    ST_WAIT_POR, ST_RUN, ST_POWERUP_TIMER, ST_OST, ST_HOLD
  } rts_state_type;

endpackage

// ===== hdl/rts_top.sv
// Purpose: reset time-out sequencer with reset cause flags
// Assumes: all inputs but sys_rst_i synchronous to clk_i; osc_tick_i one pulse per
//          oscillator period
// Notes:   registers on a plain 8-bit port, read data one cycle later
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - two select bits pick low-power, crystal, high-speed or RC oscillator mode.
// - power-up runs power-up timer first, then start-up timer, then releases reset.
// - crystal power-up waits 72 ms plus 1024 periods, or 1024 if disabled.
// - RC power-up waits 72 ms when enabled, nothing when disabled, no counting.
// - brown-out waits 72 ms plus 1024 periods, 72 ms only in RC; wake waits 1024, RC none.
// - power-up and brown-out time-outs run regardless of clear pin; a low pin ends a wake time-out; late pin release starts at once.
// - brown-out flag is bit 0, cleared by brown-out, set by software.
// - brown-out flag is meaningless while brown-out detect is disabled.
// - power-on flag is bit 1, cleared by power-on (not by brown-out), set by software.
// - the four flags together encode which reset or wake-up occurred.
// - power-on reset sets timeout and powerdown flags.
// - clear pin in sleep gives timeout 1 powerdown 0; awake leaves them.
// - resets load program counter zero; wake-ups continue at counter plus one.
// - power-on gives status 0001 1xxx; brown-out clears only brown-out flag.
// - watchdog wake clears timeout and powerdown, other status bits kept.
// - interrupt wake with global enable set loads vector 0004h.
module rts_top
  import rts_pkg::*;
#(
  parameter int POWERUP_TIMER_CYCLES = rts_pkg::POWERUP_TIMER_CYC
) (
  input  wire logic                 clk_i,        // system clock
  input  wire logic                 sys_rst_i,    // async reset
  input  wire rts_pkg::rts_bus_type bus_i,        // register port
  output logic [7:0]                rdata_o,      // read data
  input  wire rts_pkg::rts_cfg_type cfg_i,        // configuration
  input  wire rts_pkg::rts_evt_type evt_i,        // reset sources
  input  wire logic                 master_clear_pin_n_i, // clear pin
  input  wire logic                 osc_tick_i,   // osc period
  input  wire logic [12:0]          pc_i,         // current pc
  output logic                      cpu_reset_o,  // core in reset
  output logic                      pc_load_o,    // pc load pulse
  output logic [12:0]               pc_value_o,   // pc load value
  output logic [4:0]                status_top_o, // status 7:3
  output logic [1:0]                pwr_status_o, // power status
  output logic                      irq_o         // interrupt
);
  import rts_pkg::*;

  localparam logic [POWERUP_TIMER_W-1:0] POWERUP_TIMER_LAST = POWERUP_TIMER_W'(POWERUP_TIMER_CYCLES - 1);

  // ==========================================================
  // state
  rts_state_type     state_reg;
  rts_state_type     state_next;
  logic [POWERUP_TIMER_W-1:0] powerup_timer_cnt_reg;
  logic [POWERUP_TIMER_W-1:0] powerup_timer_cnt_next;
  logic [OST_W-1:0]  ost_cnt_reg;
  logic [OST_W-1:0]  ost_cnt_next;
  logic              wake_reg;
  logic              wake_next;
  logic              wirq_reg;
  logic              wirq_next;
  logic              cpu_rst_reg;
  logic              cpu_rst_next;
  logic              pc_load_reg;
  logic              pc_load_next;
  logic [12:0]       pc_val_reg;
  logic [12:0]       pc_val_next;
  logic [1:0]        pwr_reg;
  logic [1:0]        pwr_next;
  logic [4:0]        stat_reg;
  logic [4:0]        stat_next;
  logic [3:0]        ist_reg;
  logic [3:0]        ist_next;
  logic [3:0]        msk_reg;
  logic [3:0]        msk_next;
  logic              irq_reg;
  logic              irq_next;
  logic [7:0]        rdata_reg;
  logic [7:0]        rdata_next;
  logic [3:0]        ev;

  logic       crystal;
  logic       master_clear_pin_low;
  logic       bor_ev;
  logic [1:0] osc_mode;

  assign osc_mode = {cfg_i.osc_select_hi, cfg_i.osc_select_lo};
  assign crystal  = (osc_mode != OSC_RC);
  assign master_clear_pin_low = ~master_clear_pin_n_i;
  assign bor_ev   = evt_i.brownout & cfg_i.brownout_detect_enable;

  // first timed phase: power-up timer, else start-up timer, else hold
  function automatic rts_state_type first_phase(input logic powerup_timer, input logic startup_timer);
    return powerup_timer ? ST_POWERUP_TIMER : (startup_timer ? ST_OST : ST_HOLD);
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    state_next    = state_reg;
    powerup_timer_cnt_next = powerup_timer_cnt_reg;
    ost_cnt_next  = ost_cnt_reg;
    wake_next     = wake_reg;
    wirq_next     = wirq_reg;
    cpu_rst_next  = cpu_rst_reg;
    pc_load_next  = 1'b0;
    pc_val_next   = pc_val_reg;
    pwr_next      = pwr_reg;
    stat_next     = stat_reg;
    msk_next      = msk_reg;
    ist_next      = ist_reg;
    ev            = 4'h0;

    // software writes; hardware below overrides in the same cycle
    if (bus_i.we) begin
      case (bus_i.addr)
        ADDR_PWR: begin
          pwr_next = bus_i.wdata[1:0];
        end
        ADDR_STAT: begin
          stat_next = bus_i.wdata[7:3];
        end
        ADDR_IRQ_ST: begin
          ist_next = ist_reg & ~bus_i.wdata[3:0];
        end
        ADDR_IRQ_MSK: begin
          msk_next = bus_i.wdata[3:0];
        end
        default: begin
        end
      endcase
    end

    case (state_reg)
      ST_WAIT_POR: begin
      end
      ST_RUN: begin
        if (evt_i.wdt && evt_i.sleep) begin
          stat_next[STAT_TO_BIT] = 1'b0;
          stat_next[STAT_PD_BIT] = 1'b0;
          wake_next    = 1'b1;
          wirq_next    = 1'b0;
          ost_cnt_next = '0;
          state_next   = first_phase(1'b0, crystal);
          ev[EV_WAKE]  = 1'b1;
        end else if (evt_i.wdt) begin
          stat_next    = STAT_WDTR;
          cpu_rst_next = 1'b1;
          state_next   = ST_HOLD;
          ev[EV_WDT]   = 1'b1;
        end else if (evt_i.irq_wake && evt_i.sleep) begin
          stat_next[STAT_TO_BIT] = 1'b1;
          stat_next[STAT_PD_BIT] = 1'b0;
          wake_next    = 1'b1;
          wirq_next    = 1'b1;
          ost_cnt_next = '0;
          state_next   = first_phase(1'b0, crystal);
          ev[EV_WAKE]  = 1'b1;
        end
      end
      ST_POWERUP_TIMER: begin
        powerup_timer_cnt_next = POWERUP_TIMER_W'(powerup_timer_cnt_reg + 1'b1);
        if (powerup_timer_cnt_reg == POWERUP_TIMER_LAST) begin
          ost_cnt_next = '0;
          state_next   = crystal ? ST_OST : ST_HOLD;
        end
      end
      ST_OST: begin
        if (osc_tick_i) begin
          ost_cnt_next = OST_W'(ost_cnt_reg + 1'b1);
          if (ost_cnt_reg == OST_LAST) begin
            state_next = ST_HOLD;
          end
        end
      end
      ST_HOLD: begin
        if (wake_reg) begin
          pc_load_next = 1'b1;
          state_next   = ST_RUN;
          wake_next    = 1'b0;
          if (wirq_reg && cfg_i.global_irq_enable) begin
            pc_val_next = PC_IRQ_VEC;
          end else begin
            pc_val_next = pc_i + 13'h0001;
          end
        end else if (!master_clear_pin_low) begin
          cpu_rst_next = 1'b0;
          pc_load_next = 1'b1;
          pc_val_next  = PC_RESET;
          state_next   = ST_RUN;
          ev[EV_REL]   = 1'b1;
        end
      end
      default: begin
        state_next = ST_WAIT_POR;
      end
    endcase

    // reset sources, highest priority first
    if (evt_i.por) begin
      pwr_next[PWR_POR_BIT] = 1'b0;
      stat_next     = STAT_POR;
      cpu_rst_next  = 1'b1;
      wake_next     = 1'b0;
      pc_load_next  = 1'b0;
      powerup_timer_cnt_next = '0;
      ost_cnt_next  = '0;
      state_next    = first_phase(~cfg_i.powerup_timer_enable_n,
                                  crystal);
    end else if (bor_ev) begin
      pwr_next[PWR_BOR_BIT] = 1'b0;
      stat_next     = STAT_POR;
      cpu_rst_next  = 1'b1;
      wake_next     = 1'b0;
      pc_load_next  = 1'b0;
      powerup_timer_cnt_next = '0;
      ost_cnt_next  = '0;
      state_next    = ST_POWERUP_TIMER;
      ev            = 4'h0;
      ev[EV_BOR]    = 1'b1;
    end else if (master_clear_pin_low && (state_reg == ST_RUN || wake_reg)) begin
      if (evt_i.sleep || wake_reg) begin
        stat_next = STAT_MSLP;
      end else begin
        stat_next[4:2] = 3'h0;
      end
      cpu_rst_next = 1'b1;
      wake_next    = 1'b0;
      pc_load_next = 1'b0;
      state_next   = ST_HOLD;
      ev           = 4'h0;
    end

    ist_next = ist_next | ev;
    irq_next = |(ist_next & msk_next);

    rdata_next = 8'h00;
    if (bus_i.re) begin
      case (bus_i.addr)
        ADDR_PWR:     rdata_next = {6'h00, pwr_reg};
        ADDR_STAT:    rdata_next = {stat_reg, 3'h0};
        ADDR_IRQ_ST:  rdata_next = {4'h0, ist_reg};
        ADDR_IRQ_MSK: rdata_next = {4'h0, msk_reg};
        ADDR_STATE:   rdata_next = {3'h0, cpu_rst_reg, wake_reg,
                                    state_reg};
        default:      rdata_next = 8'h00;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg    <= ST_WAIT_POR;
      powerup_timer_cnt_reg <= '0;
      ost_cnt_reg  <= '0;
      wake_reg     <= 1'b0;
      wirq_reg     <= 1'b0;
      cpu_rst_reg  <= 1'b1;
      pc_load_reg  <= 1'b0;
      pc_val_reg   <= PC_RESET;
      pwr_reg      <= PWR_RST;
      stat_reg     <= STAT_POR;
      ist_reg      <= IRQ_RST;
      msk_reg      <= IRQ_RST;
      irq_reg      <= 1'b0;
      rdata_reg    <= 8'h00;
    end else begin
      state_reg    <= state_next;
      powerup_timer_cnt_reg <= powerup_timer_cnt_next;
      ost_cnt_reg  <= ost_cnt_next;
      wake_reg     <= wake_next;
      wirq_reg     <= wirq_next;
      cpu_rst_reg  <= cpu_rst_next;
      pc_load_reg  <= pc_load_next;
      pc_val_reg   <= pc_val_next;
      pwr_reg      <= pwr_next;
      stat_reg     <= stat_next;
      ist_reg      <= ist_next;
      msk_reg      <= msk_next;
      irq_reg      <= irq_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign rdata_o      = rdata_reg;
  assign cpu_reset_o  = cpu_rst_reg;
  assign pc_load_o    = pc_load_reg;
  assign pc_value_o   = pc_val_reg;
  assign status_top_o = stat_reg;
  assign pwr_status_o = pwr_reg;
  assign irq_o        = irq_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  logic quiet;
  assign quiet = ~evt_i.por & ~bor_ev;

  a_por_flags: assert property (
    evt_i.por |=> !pwr_reg[PWR_POR_BIT] && stat_reg == STAT_POR
                  && cpu_reset_o)
    else $error("power-on flags wrong");

  a_bor_clear: assert property (
    bor_ev && !evt_i.por |=> !pwr_reg[PWR_BOR_BIT]
                             && state_reg == ST_POWERUP_TIMER)
    else $error("brown-out flag not cleared");

  a_rc_timer_skip: assert property (
    evt_i.por && !crystal && cfg_i.powerup_timer_enable_n
    |=> state_reg == ST_HOLD)
    else $error("rc mode ran a time-out");

  a_powerup_timer_end: assert property (
    state_reg == ST_POWERUP_TIMER && powerup_timer_cnt_reg == POWERUP_TIMER_LAST && quiet
    |=> state_reg == (crystal ? ST_OST : ST_HOLD))
    else $error("power-up timer length wrong");

  a_ost_end: assert property (
    state_reg == ST_OST && osc_tick_i && ost_cnt_reg == OST_LAST
    && quiet && !(master_clear_pin_low && wake_reg) |=> state_reg == ST_HOLD)
    else $error("start-up timer length wrong");

  a_release_pc: assert property (
    $fell(cpu_reset_o) |-> pc_load_o && pc_value_o == PC_RESET)
    else $error("reset release without pc zero");

  a_irq_vector: assert property (
    state_reg == ST_HOLD && wake_reg && wirq_reg && quiet
    && cfg_i.global_irq_enable && !master_clear_pin_low
    |=> pc_load_o && pc_value_o == PC_IRQ_VEC)
    else $error("interrupt vector not loaded");

  a_wdt_wake: assert property (
    state_reg == ST_RUN && evt_i.wdt && evt_i.sleep && quiet
    && !master_clear_pin_low |=> stat_reg[4:2] == $past(stat_reg[4:2])
    && !stat_reg[STAT_TO_BIT] && !stat_reg[STAT_PD_BIT]
    && !cpu_reset_o)
    else $error("watchdog wake flags wrong");

  a_master_clear_pin_sleep: assert property (
    state_reg == ST_RUN && master_clear_pin_low && evt_i.sleep && quiet
    |=> stat_reg == STAT_MSLP && cpu_reset_o)
    else $error("clear in sleep flags wrong");

  a_master_clear_pin_hold: assert property (
    state_reg == ST_HOLD && !wake_reg && master_clear_pin_low && quiet
    |=> cpu_reset_o && state_reg == ST_HOLD)
    else $error("released while clear pin low");

  a_irq_level: assert property (
    ist_reg == 4'h0 |-> !irq_o)
    else $error("interrupt with no status");

  c_por_release: cover property (
    evt_i.por ##[1:1000] $fell(cpu_reset_o));
  c_wdt_wake: cover property (
    state_reg == ST_RUN && evt_i.wdt && evt_i.sleep);
  c_irq_wake: cover property (
    pc_load_o && pc_value_o == PC_IRQ_VEC);
  c_bor: cover property (bor_ev && state_reg == ST_RUN);

endmodule

// ===== tb/rts_supply_model.sv
// Purpose: far side of the sequencer: supply monitor, clear pin, oscillator
// Assumes: oscillator already running, one tick every TICK_DIV clocks
// Notes:   pulses are requested by the bench through the tasks below
`timescale 1ns/1ps

module rts_supply_model #(
  parameter int TICK_DIV = 4
) (
  input  wire logic clk_i,      // system clock
  output logic      por_o,      // power-on pulse
  output logic      brownout_o, // brown-out detect
  output logic      pin_n_o,    // clear pin level
  output logic      osc_tick_o  // one pulse per osc period
);
  int div_cnt;

  initial begin
    por_o = 1'b0;
    brownout_o = 1'b0;
    pin_n_o = 1'b1;
    osc_tick_o = 1'b0;
    div_cnt = 0;
  end

  // ==========================================================
  // oscillator runs free, one tick pulse per period
  always @(posedge clk_i) begin
    div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
    osc_tick_o <= (div_cnt == TICK_DIV - 1);
  end

  // ==========================================================
  // supply events, one cycle each; clear pin level held until the next call
  task pulse(input logic bo);
    @(posedge clk_i);
    if (bo) brownout_o <= 1'b1;
    else por_o <= 1'b1;
    @(posedge clk_i);
    por_o <= 1'b0;
    brownout_o <= 1'b0;
  endtask

  task pin(input logic lvl);
    @(posedge clk_i);
    pin_n_o <= lvl;
  endtask
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench of the reset time-out sequencer
// Assumes: short power-up delay parameter, oscillator tick every TP clocks
// Notes:   inputs change by non-blocking assignment at rising edges; slp and pc also at falling edges
`timescale 1ns/1ps

module testbench;
  import rts_pkg::*;
  localparam int P  = 20;
  localparam int TP = 4;
  logic        clk_i, sys_rst_i, wdt, iw, slp, por, bo, pin_n, tick;
  rts_bus_type bus;
  rts_cfg_type cfg;
  rts_evt_type evt;
  logic [12:0] pc, pcv;
  logic [7:0]  rdata;
  logic [4:0]  st;
  logic [1:0]  pwr;
  logic        cpu_rst, ld, irq;
  int          fails, checks_done, n, e;

  assign evt = '{por: por, brownout: bo, wdt: wdt, irq_wake: iw, sleep: slp};

  rts_supply_model #(.TICK_DIV(TP)) m (.clk_i(clk_i), .por_o(por), .brownout_o(bo), .pin_n_o(pin_n),
    .osc_tick_o(tick));

  rts_top #(.POWERUP_TIMER_CYCLES(P)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata),
    .cfg_i(cfg), .evt_i(evt), .master_clear_pin_n_i(pin_n), .osc_tick_i(tick), .pc_i(pc),
    .cpu_reset_o(cpu_rst), .pc_load_o(ld), .pc_value_o(pcv), .status_top_o(st),
    .pwr_status_o(pwr), .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // shared tasks
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task test_done;
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task settle(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    bus.we <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    bus.re <= 1'b0;
    @(negedge clk_i);
    chk(rdata, x);
  endtask

  task setcfg(input logic [1:0] md, input logic en_n, input logic g);
    @(posedge clk_i);
    cfg <= '{osc_select_hi: md[1], osc_select_lo: md[0], powerup_timer_enable_n: en_n,
             brownout_detect_enable: 1'b1, global_irq_enable: g};
  endtask

  task ev(input logic w);
    @(posedge clk_i);
    if (w) wdt <= 1'b1;
    else iw <= 1'b1;
    @(posedge clk_i);
    wdt <= 1'b0;
    iw <= 1'b0;
  endtask

  // counts cycles until the load pulse, bounded
  task wait_ld(input int mx);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      if (n > mx) begin
        fails++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, n, mx);
        test_done();
      end
    end while (ld !== 1'b1);
  endtask

  task chk_len;
    chk(24'(n + TP >= e && n <= e + TP + 4), 24'h1);
  endtask

  // ==========================================================
  // scenarios
  task t_power;
    for (logic [3:0] i = 0; i < 8; i++) begin
      setcfg(i[2:1], i[0], 1'b0);
      wr(ADDR_PWR, 8'h03);
      m.pulse(1'b0);
      wait_ld(6000);
      e = (i[2:1] == OSC_RC ? 0 : 1024 * TP) + (i[0] ? 0 : P);
      chk_len();
      chk({pcv, st}, {PC_RESET, STAT_POR});
      chk(pwr[PWR_POR_BIT], 1'b0);
    end
  endtask

  task t_pin;
    setcfg(OSC_XT, 1'b0, 1'b0);
    m.pin(1'b0);
    m.pulse(1'b0);
    settle(P + 1026 * TP + 10);
    chk(cpu_rst, 1'b1);
    m.pin(1'b1);
    wait_ld(6);
    chk(24'(n <= 3), 24'h1);
  endtask

  task t_brown;
    for (int k = 0; k < 2; k++) begin
      setcfg(k ? OSC_RC : OSC_HS, 1'b1, 1'b0);
      wr(ADDR_PWR, 8'h03);
      m.pulse(1'b1);
      wait_ld(6000);
      e = P + (k ? 0 : 1024 * TP);
      chk_len();
      chk(pwr, 2'h2);
    end
    settle(2);
    chk(irq, 1'b1);
    rd(ADDR_IRQ_ST, 8'h03);
    wr(ADDR_IRQ_ST, 8'h02);
    settle(2);
    chk(irq, 1'b0);
    rd(ADDR_IRQ_ST, 8'h01);
    // brown-out input must be ignored while detection is disabled
    @(posedge clk_i);
    cfg.brownout_detect_enable <= 1'b0;
    wr(ADDR_PWR, 8'h03);
    m.pulse(1'b1);
    settle(3);
    chk({cpu_rst, pwr}, {1'b0, 2'h3});
    rd(ADDR_IRQ_ST, 8'h01);
  endtask

  task t_wdt;
    setcfg(OSC_RC, 1'b1, 1'b0);
    wr(ADDR_PWR, 8'h03);
    ev(1'b1);
    wait_ld(20);
    chk({pcv, st}, {PC_RESET, STAT_WDTR});
    chk(pwr, 2'h3);
  endtask

  task t_wake;
    setcfg(OSC_LP, 1'b1, 1'b0);
    wr(ADDR_STAT, 8'hb8);
    slp <= 1'b1;
    ev(1'b1);
    wait_ld(6000);
    e = 1024 * TP;
    chk_len();
    chk({cpu_rst, pcv, st}, {1'b0, pc + 13'h1, 5'h14});
    slp <= 1'b0;
    pc <= 13'h1abc;
    for (int g = 0; g < 2; g++) begin
      setcfg(OSC_RC, 1'b1, g[0]);
      wr(ADDR_STAT, 8'hb8);
      slp <= 1'b1;
      ev(1'b0);
      wait_ld(20);
      chk({pcv, st}, {g ? PC_IRQ_VEC : pc + 13'h1, 5'h16});
      slp <= 1'b0;
    end
  endtask

  task t_clear;
    wr(ADDR_STAT, 8'hf8);
    m.pin(1'b0);
    settle(3);
    chk({cpu_rst, st}, {1'b1, 5'h03});
    m.pin(1'b1);
    wait_ld(6);
    chk(pcv, PC_RESET);
    slp <= 1'b1;
    m.pin(1'b0);
    settle(3);
    chk({cpu_rst, st}, {1'b1, 5'h02});
    slp <= 1'b0;
    m.pin(1'b1);
    wait_ld(6);
    chk(pcv, PC_RESET);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    fails = 0;
    checks_done = 0;
    sys_rst_i = 1'b1;
    bus = '0;
    cfg = '0;
    wdt = 1'b0;
    iw = 1'b0;
    slp = 1'b0;
    pc = 13'h0123;
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    settle(1);
    chk({cpu_rst, st, pwr}, {1'b1, STAT_POR, PWR_RST});
    rd(ADDR_STAT, 8'h18);
    rd(4'h7, 8'h00);
    wr(ADDR_IRQ_MSK, 8'h02);
    t_power();
    t_pin();
    t_brown();
    t_wdt();
    t_wake();
    t_clear();
    test_done();
  end
endmodule
